// >>> logic/smie_pkg.sv
// Package of constants and types for the shift, move and indirect load unit.
`default_nettype none
package smie_pkg;
  // ********************
  // Bus map
  // ********************
  localparam int ADR_W = 11;
  localparam logic [10:0] ADR_CMD = 11'h000;
  localparam logic [10:0] ADR_WREG = 11'h004;
  localparam logic [10:0] ADR_STATUS = 11'h008;
  localparam logic [10:0] ADR_PTR0 = 11'h00C;
  localparam logic [10:0] ADR_PTR1 = 11'h010;
  localparam int MEM_SEL_BIT = 10;
  localparam int MEM_AW = 8;
  // ********************
  // Command word fields
  // ********************
  localparam int CMD_F_LSB = 0;
  localparam int CMD_D_BIT = 7;
  localparam int CMD_OP_LSB = 8;
  localparam int CMD_PTR_BIT = 10;
  localparam int CMD_REL_BIT = 11;
  localparam int CMD_CODE_LSB = 12;
  localparam int CMD_OFF_LSB = 14;
  // ********************
  // Status fields and reset values
  // ********************
  localparam int STAT_C_BIT = 0;
  localparam int STAT_Z_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [31:0] CMD_RST = 32'h0000_0000;
  // ********************
  // Types
  // ********************
  typedef enum logic [1:0] {
    SMIE_LOGICAL_SHIFT_LEFT_OP = 2'h0,
    SMIE_LOGICAL_SHIFT_RIGHT_OP = 2'h1,
    SMIE_MOVE_FILE_OP = 2'h2,
    SMIE_INDIRECT_LOAD_OP = 2'h3
  } smie_op_t;
  typedef enum logic [1:0] {
    SMIE_PRE_INC = 2'h0,
    SMIE_PRE_DEC = 2'h1,
    SMIE_POST_INC = 2'h2,
    SMIE_POST_DEC = 2'h3
  } smie_code_t;
  typedef enum logic [2:0] {
    SMIE_IDLE = 3'h1,
    SMIE_FETCH = 3'h2,
    SMIE_EXEC = 3'h4
  } smie_state_t;
endpackage : smie_pkg
`default_nettype wire

// >>> logic/smie_data_mem.sv
// Byte-wide data memory with registered read data.
`default_nettype none
module smie_data_mem
  import smie_pkg::*;
(
  input wire logic clk_sys,
  input wire logic we,
  input wire logic [MEM_AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] store [0:(1<<MEM_AW)-1];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      store[addr] <= wdata;
    end
    rdata <= store[addr];
  end
endmodule : smie_data_mem
`default_nettype wire

// >>> logic/smie_exec.sv
// Execution unit for shifts, file move and indirect load, Wishbone slave.
//
// Local design decisions: the Wishbone slave port and the address map.
`default_nettype none
module smie_exec
  import smie_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  // ********************
  // Functions
  // ********************
  function automatic logic [31:0] bmerge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : bmerge
  function automatic logic [15:0] step(input logic [15:0] p,
      input logic dec);
    return dec ? p - 16'h0001 : p + 16'h0001;
  endfunction : step
  function automatic logic [15:0] lane16(input logic [15:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
    return {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction : lane16
  // ********************
  // Declarations
  // ********************
  smie_state_t state, next_state;
  smie_op_t op_q, c_op;
  smie_code_t c_code;
  logic req_q, mem_rd_q, carry, zero, d_q, is_mem, bus_wr, start;
  logic c_idx, c_rel, c_d, res_c, to_w, mem_we;
  logic [31:0] reg_rdata, cmd;
  logic [15:0] ptr0, ptr1, ea, pval, next_ea, next_ptr;
  logic [7:0] wreg, mem_rdata, res, mem_wdata;
  logic [6:0] c_f;
  logic [5:0] c_off;
  logic [MEM_AW-1:0] mem_addr;
  // ********************
  // Bus slave
  // ********************
  assign is_mem = wb_adr_i[MEM_SEL_BIT];
  assign bus_wr = req_q & wb_we_i;
  assign start = bus_wr & !is_mem & (wb_adr_i == ADR_CMD);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      req_q <= 1'b0;
      wb_ack_o <= 1'b0;
      mem_rd_q <= 1'b0;
    end else begin
      req_q <= wb_cyc_i & wb_stb_i & !req_q & !wb_ack_o &
               (state == SMIE_IDLE);
      wb_ack_o <= req_q;
      mem_rd_q <= req_q & is_mem;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (req_q) begin
      if (is_mem) begin
        reg_rdata <= 32'h0000_0000;
      end else if (wb_adr_i == ADR_CMD) begin
        reg_rdata <= cmd;
      end else if (wb_adr_i == ADR_WREG) begin
        reg_rdata <= {24'h00_0000, wreg};
      end else if (wb_adr_i == ADR_STATUS) begin
        reg_rdata <= {29'h0000_0000, 1'b0, zero, carry};
      end else if (wb_adr_i == ADR_PTR0) begin
        reg_rdata <= {16'h0000, ptr0};
      end else if (wb_adr_i == ADR_PTR1) begin
        reg_rdata <= {16'h0000, ptr1};
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end
  end
  assign wb_dat_o = mem_rd_q ? {24'h00_0000, mem_rdata} : reg_rdata;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmd <= CMD_RST;
    end else if (start) begin
      cmd <= bmerge(cmd, wb_dat_i, wb_sel_i);
    end
  end
  // ********************
  // Command decode and effective address
  // ********************
  always_comb begin
    logic [31:0] nc;
    nc = bmerge(cmd, wb_dat_i, wb_sel_i);
    c_f = nc[CMD_F_LSB +: 7];
    c_op = smie_op_t'(nc[CMD_OP_LSB +: 2]);
    c_idx = nc[CMD_PTR_BIT];
    c_rel = nc[CMD_REL_BIT];
    c_code = smie_code_t'(nc[CMD_CODE_LSB +: 2]);
    c_off = nc[CMD_OFF_LSB +: 6];
    c_d = nc[CMD_D_BIT];
  end
  always_comb begin
    pval = c_idx ? ptr1 : ptr0;
    next_ptr = pval;
    next_ea = {9'h000, c_f};
    if (c_op == SMIE_INDIRECT_LOAD_OP) begin
      if (c_rel) begin
        next_ea = pval + {{10{c_off[5]}}, c_off};
      end else begin
        case (c_code)
          SMIE_PRE_INC, SMIE_PRE_DEC: begin
            next_ptr = step(pval, c_code[0]);
            next_ea = next_ptr;
          end
          default: begin
            next_ptr = step(pval, c_code[0]);
            next_ea = pval;
          end
        endcase
      end
    end else if (c_f == 7'h00) begin
      next_ea = ptr0;
    end else if (c_f == 7'h01) begin
      next_ea = ptr1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ea <= 16'h0000;
      op_q <= SMIE_LOGICAL_SHIFT_LEFT_OP;
      d_q <= 1'b0;
    end else if (start) begin
      ea <= next_ea;
      op_q <= c_op;
      d_q <= c_d;
    end
  end
  // ********************
  // Sequencer
  // ********************
  always_comb begin
    case (state)
      SMIE_IDLE: next_state = start ? SMIE_FETCH : SMIE_IDLE;
      SMIE_FETCH: next_state = SMIE_EXEC;
      SMIE_EXEC: next_state = SMIE_IDLE;
      default: next_state = SMIE_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= SMIE_IDLE;
    end else begin
      state <= next_state;
    end
  end
  // ********************
  // Datapath
  // ********************
  always_comb begin
    res_c = carry;
    case (op_q)
      SMIE_LOGICAL_SHIFT_LEFT_OP: begin
        res = {mem_rdata[6:0], 1'b0};
        res_c = mem_rdata[7];
      end
      SMIE_LOGICAL_SHIFT_RIGHT_OP: begin
        res = {1'b0, mem_rdata[7:1]};
        res_c = mem_rdata[0];
      end
      default: res = mem_rdata;
    endcase
  end
  assign to_w = (op_q == SMIE_INDIRECT_LOAD_OP) | !d_q;
  assign mem_we = ((state == SMIE_EXEC) & !to_w) |
                  (bus_wr & is_mem & wb_sel_i[0]);
  assign mem_addr = (state == SMIE_IDLE) ? wb_adr_i[9:2] : ea[7:0];
  assign mem_wdata = (state == SMIE_EXEC) ? res : wb_dat_i[7:0];
  smie_data_mem u_mem (
    .clk_sys(clk_sys),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wreg <= WREG_RST;
    end else if ((state == SMIE_EXEC) & to_w) begin
      wreg <= res;
    end else if (bus_wr & !is_mem & (wb_adr_i == ADR_WREG) & wb_sel_i[0]) begin
      wreg <= wb_dat_i[7:0];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      carry <= 1'b0;
      zero <= 1'b0;
    end else if (state == SMIE_EXEC) begin
      zero <= (res == 8'h00);
      if (op_q == SMIE_LOGICAL_SHIFT_LEFT_OP ||
          op_q == SMIE_LOGICAL_SHIFT_RIGHT_OP) begin
        carry <= res_c;
      end
    end else if (bus_wr & !is_mem & (wb_adr_i == ADR_STATUS) &
                 wb_sel_i[0]) begin
      carry <= wb_dat_i[STAT_C_BIT];
      zero <= wb_dat_i[STAT_Z_BIT];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ptr0 <= PTR_RST;
    end else if (start & (c_op == SMIE_INDIRECT_LOAD_OP) & !c_idx) begin
      ptr0 <= next_ptr;
    end else if (bus_wr & !is_mem & (wb_adr_i == ADR_PTR0)) begin
      ptr0 <= lane16(ptr0, wb_dat_i, wb_sel_i);
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ptr1 <= PTR_RST;
    end else if (start & (c_op == SMIE_INDIRECT_LOAD_OP) & c_idx) begin
      ptr1 <= next_ptr;
    end else if (bus_wr & !is_mem & (wb_adr_i == ADR_PTR1)) begin
      ptr1 <= lane16(ptr1, wb_dat_i, wb_sel_i);
    end
  end
  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  logic exec_ind;
  assign exec_ind = start & (c_op == SMIE_INDIRECT_LOAD_OP) & !c_idx &
                    !c_rel;

  a_lsl_to_w: assert property (
    state == SMIE_EXEC && op_q == SMIE_LOGICAL_SHIFT_LEFT_OP && !d_q |=>
    wreg == {$past(mem_rdata[6:0]), 1'b0} && carry == $past(mem_rdata[7]))
    else $error("left shift result wrong");
  a_lsr_to_file: assert property (
    state == SMIE_EXEC && op_q == SMIE_LOGICAL_SHIFT_RIGHT_OP && d_q |->
    mem_we && mem_wdata == {1'b0, mem_rdata[7:1]} ##1
    carry == $past(mem_rdata[0]))
    else $error("right shift result wrong");
  a_shift_dest: assert property (
    state == SMIE_EXEC && op_q != SMIE_INDIRECT_LOAD_OP && !d_q |->
    !mem_we)
    else $error("shift to working register wrote memory");
  a_move_copy: assert property (
    state == SMIE_EXEC && op_q == SMIE_MOVE_FILE_OP && d_q |->
    mem_we && mem_wdata == mem_rdata && mem_addr == ea[7:0])
    else $error("file move did not copy back");
  a_move_zero: assert property (
    state == SMIE_EXEC && op_q == SMIE_MOVE_FILE_OP |=>
    zero == ($past(mem_rdata) == 8'h00))
    else $error("file move zero flag wrong");
  a_load_w: assert property (
    state == SMIE_EXEC && op_q == SMIE_INDIRECT_LOAD_OP |=>
    wreg == $past(mem_rdata) && zero == (wreg == 8'h00))
    else $error("indirect load wrong");
  a_pre_inc: assert property (
    exec_ind && c_code == SMIE_PRE_INC |=>
    ptr0 == $past(ptr0) + 16'h0001 && ea == ptr0)
    else $error("pre-increment wrong");
  a_post_dec: assert property (
    exec_ind && c_code == SMIE_POST_DEC |=>
    ea == $past(ptr0) && ptr0 == $past(ptr0) - 16'h0001)
    else $error("post-decrement wrong");
  a_rel_hold: assert property (
    start && c_op == SMIE_INDIRECT_LOAD_OP && c_rel |=> $stable(ptr0) &&
    $stable(ptr1))
    else $error("relative form moved pointer");
  a_window_map: assert property (
    start && c_op != SMIE_INDIRECT_LOAD_OP && c_f == 7'h00 |=>
    ea == ptr0 ##1 mem_addr == ptr0[7:0])
    else $error("window not redirected");
  a_ptr_wrap: assert property (
    exec_ind && c_code == SMIE_PRE_INC && ptr0 == 16'hFFFF |=>
    ptr0 == 16'h0000)
    else $error("pointer did not wrap");
  a_flags_keep: assert property (
    start |=> $stable(carry) && $stable(zero))
    else $error("pointer step touched flags");
  a_exec_time: assert property (
    start |=> state == SMIE_FETCH ##1 state == SMIE_EXEC ##1
    state == SMIE_IDLE)
    else $error("execution sequence wrong");
  a_ptr_select: assert property (
    start && c_op == SMIE_INDIRECT_LOAD_OP && c_idx |=> $stable(ptr0))
    else $error("wrong pointer stepped");

  c_lsl: cover property (state == SMIE_EXEC &&
    op_q == SMIE_LOGICAL_SHIFT_LEFT_OP);
  c_self_move: cover property (state == SMIE_EXEC &&
    op_q == SMIE_MOVE_FILE_OP && d_q && mem_rdata == 8'h00);
  c_wrap: cover property (exec_ind && ptr0 == 16'h0000 &&
    c_code == SMIE_PRE_DEC);
  c_rel_load: cover property (start && c_op == SMIE_INDIRECT_LOAD_OP &&
    c_rel);
endmodule : smie_exec
`default_nettype wire

// >>> testbench/shift_move_indirect_exec_bench.sv
// Self-checking testbench for the shift, move and indirect load unit.
`default_nettype none
module shift_move_indirect_exec_bench
  import smie_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // Signals and instance
  // ********************
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [31:0] wdat = '0;
  logic [3:0] sel = 4'h0;
  logic [31:0] rdat;
  logic ack;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  smie_exec dut (
    .clk_sys(clk_sys), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack)
  );
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // ********************
  // Bus and check tasks
  // ********************
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    forever begin
      @(posedge clk_sys);
      cycles++;
      if (cycles > 20000) begin
        n_mismatch++;
        tally_and_finish();
      end
    end
  end
  task automatic xfer(input logic w, input logic [10:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1);
    r = rdat;
    if (n != 3) begin
      $display("FAIL ack latency expected 3 seen %0d", n);
      n_mismatch++;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr
  task automatic chk(input string nm, input logic [10:0] a,
                     input logic [31:0] e, input logic [31:0] m);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    cmp_count++;
    if ((r & m) !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, r & m);
      n_mismatch++;
    end
  endtask : chk
  function automatic logic [10:0] ma(input logic [7:0] i);
    return {1'b1, i, 2'h0};
  endfunction : ma
  function automatic logic [31:0] mk(input logic [1:0] op,
      input logic [6:0] f, input logic d, input logic p, input logic rl,
      input logic [1:0] c, input logic [5:0] o);
    return (32'(f) << CMD_F_LSB) | (32'(d) << CMD_D_BIT)
      | (32'(op) << CMD_OP_LSB) | (32'(p) << CMD_PTR_BIT)
      | (32'(rl) << CMD_REL_BIT) | (32'(c) << CMD_CODE_LSB)
      | (32'(o) << CMD_OFF_LSB);
  endfunction : mk
  task automatic op_f(input logic [1:0] op, input logic [6:0] f,
                      input logic d, input logic [7:0] v);
    wr(ma({1'b0, f}), {24'h0, v});
    wr(ADR_CMD, mk(op, f, d, 1'b0, 1'b0, 2'h0, 6'h00));
  endtask : op_f
  task automatic ind(input logic p, input logic rl, input logic [1:0] c,
                     input logic [5:0] o, input logic [15:0] p0);
    wr(p ? ADR_PTR1 : ADR_PTR0, {16'h0, p0});
    wr(ADR_CMD, mk(SMIE_INDIRECT_LOAD_OP, 7'h00, 1'b0, p, rl, c, o));
  endtask : ind
  // ********************
  // Scenarios
  // ********************
  task automatic t_reset();
    chk("cmd", ADR_CMD, CMD_RST, 32'hFFFF_FFFF);
    chk("w", ADR_WREG, {24'h0, WREG_RST}, 32'hFF);
    chk("status", ADR_STATUS, 32'h0, 32'h3);
    chk("ptr0", ADR_PTR0, {16'h0, PTR_RST}, 32'hFFFF);
    chk("ptr1", ADR_PTR1, {16'h0, PTR_RST}, 32'hFFFF);
    wr(11'h014, 32'hFFFF_FFFF);
    chk("unmapped", 11'h014, 32'h0, 32'hFFFF_FFFF);
    $display("test reset done");
  endtask : t_reset
  task automatic t_shift();
    op_f(SMIE_LOGICAL_SHIFT_LEFT_OP, 7'h10, 1'b0, 8'h81);
    chk("shl w", ADR_WREG, 32'h02, 32'hFF);
    chk("shl cz", ADR_STATUS, 32'h1, 32'h3);
    chk("shl file kept", ma(8'h10), 32'h81, 32'hFF);
    op_f(SMIE_LOGICAL_SHIFT_LEFT_OP, 7'h10, 1'b1, 8'h80);
    chk("shl file", ma(8'h10), 32'h00, 32'hFF);
    chk("shl w kept", ADR_WREG, 32'h02, 32'hFF);
    chk("shl cz", ADR_STATUS, 32'h3, 32'h3);
    op_f(SMIE_LOGICAL_SHIFT_RIGHT_OP, 7'h11, 1'b0, 8'h01);
    chk("shr w", ADR_WREG, 32'h00, 32'hFF);
    chk("shr cz", ADR_STATUS, 32'h3, 32'h3);
    op_f(SMIE_LOGICAL_SHIFT_RIGHT_OP, 7'h7F, 1'b1, 8'hFE);
    chk("shr file", ma(8'h7F), 32'h7F, 32'hFF);
    chk("shr cz", ADR_STATUS, 32'h0, 32'h3);
    $display("test shift done");
  endtask : t_shift
  task automatic t_move();
    wr(ADR_STATUS, 32'h1);
    op_f(SMIE_MOVE_FILE_OP, 7'h12, 1'b1, 8'h00);
    chk("mov self", ma(8'h12), 32'h00, 32'hFF);
    chk("mov z", ADR_STATUS, 32'h3, 32'h3);
    op_f(SMIE_MOVE_FILE_OP, 7'h13, 1'b0, 8'h5A);
    chk("mov w", ADR_WREG, 32'h5A, 32'hFF);
    chk("mov z", ADR_STATUS, 32'h1, 32'h3);
    $display("test move done");
  endtask : t_move
  task automatic t_ind();
    wr(ma(8'h00), 32'h11);
    wr(ma(8'hFF), 32'h22);
    wr(ma(8'h20), 32'h00);
    wr(ma(8'h30), 32'h44);
    wr(ma(8'h5F), 32'h66);
    wr(ADR_STATUS, 32'h1);
    ind(1'b0, 1'b0, SMIE_PRE_INC, 6'h00, 16'hFFFF);
    chk("pre inc w", ADR_WREG, 32'h11, 32'hFF);
    chk("pre inc p", ADR_PTR0, 32'h0000, 32'hFFFF);
    chk("pre inc cz", ADR_STATUS, 32'h1, 32'h3);
    ind(1'b0, 1'b0, SMIE_PRE_DEC, 6'h00, 16'h0000);
    chk("pre dec w", ADR_WREG, 32'h22, 32'hFF);
    chk("pre dec p", ADR_PTR0, 32'hFFFF, 32'hFFFF);
    ind(1'b1, 1'b0, SMIE_POST_INC, 6'h00, 16'h0020);
    chk("post inc w", ADR_WREG, 32'h00, 32'hFF);
    chk("post inc p", ADR_PTR1, 32'h0021, 32'hFFFF);
    chk("post inc cz", ADR_STATUS, 32'h3, 32'h3);
    ind(1'b0, 1'b0, SMIE_POST_DEC, 6'h00, 16'h0030);
    chk("post dec w", ADR_WREG, 32'h44, 32'hFF);
    chk("post dec p", ADR_PTR0, 32'h002F, 32'hFFFF);
    chk("other ptr", ADR_PTR1, 32'h0021, 32'hFFFF);
    ind(1'b1, 1'b1, SMIE_PRE_INC, 6'h20, 16'h0040);
    chk("rel low w", ADR_WREG, 32'h00, 32'hFF);
    ind(1'b1, 1'b1, SMIE_POST_DEC, 6'h1F, 16'h0040);
    chk("rel high w", ADR_WREG, 32'h66, 32'hFF);
    chk("rel p", ADR_PTR1, 32'h0040, 32'hFFFF);
    chk("rel cz", ADR_STATUS, 32'h1, 32'h3);
    $display("test indirect done");
  endtask : t_ind
  task automatic t_window();
    wr(ADR_PTR0, 32'h0050);
    wr(ma(8'h50), 32'h77);
    wr(ADR_CMD, mk(SMIE_MOVE_FILE_OP, 7'h00, 1'b0, 1'b0, 1'b0, 2'h0, 6'h0));
    chk("win w", ADR_WREG, 32'h77, 32'hFF);
    chk("win p", ADR_PTR0, 32'h0050, 32'hFFFF);
    wr(ADR_PTR1, 32'h0051);
    wr(ma(8'h51), 32'h03);
    wr(ADR_CMD, mk(SMIE_LOGICAL_SHIFT_LEFT_OP, 7'h01, 1'b1, 1'b0, 1'b0,
                   2'h0, 6'h0));
    chk("win file", ma(8'h51), 32'h06, 32'hFF);
    chk("win cz", ADR_STATUS, 32'h0, 32'h3);
    $display("test window done");
  endtask : t_window
  // ********************
  // Main sequence
  // ********************
  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_shift();
    t_move();
    t_ind();
    t_window();
    tally_and_finish();
  end
endmodule : shift_move_indirect_exec_bench
`default_nettype wire
